// ===== modem_link_pkg.sv
// Shared constants and types for the modem host port link
package modem_link_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLOCK_HZ          = 250_000_000;
  localparam int unsigned BAUD_RATE         = 115_200;
  localparam int unsigned BIT_CYCLES        = CLOCK_HZ / BAUD_RATE;
  localparam int unsigned HALF_BIT_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned RESET_PULSE_MS    = 5;
  localparam int unsigned RESET_PULSE_CYC   = (CLOCK_HZ / 1000) * RESET_PULSE_MS;
  localparam int unsigned RING_PULSE_CYCLES = BIT_CYCLES * 8;

  // ----------------------------------------
  // Character framing
  // ----------------------------------------
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned STOP_BITS  = 1;
  localparam int unsigned CNT_W      = 32;
  localparam logic        LINE_IDLE  = 1'b1;
  localparam logic        START_BIT  = 1'b0;

  // ----------------------------------------
  // Serial engine states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } ser_state_t;

  typedef logic [DATA_BITS-1:0] char_t;

  // Counter reached bound
  function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int unsigned lim);
    return c >= CNT_W'(lim - 1);
  endfunction

endpackage

// ===== modem_link_if.sv
// Pin-level carrier between host and modem ends
interface modem_link_if;
  // Serial and handshake lines
  logic tx_data;      // Host to modem
  logic rx_data_o;    // Modem drive value
  logic rx_data_oe_n; // Low while modem drives
  logic dcd_o;
  logic dcd_oe_n;
  logic dsr_o;
  logic dsr_oe_n;
  logic cts_o;
  logic cts_oe_n;
  logic ri_o;
  logic ri_oe_n;
  logic dtr_n;
  logic rts;
  // Power and reset
  logic power_enable_in;
  logic module_reset_n;

  modport modem (
    input  tx_data, dtr_n, rts, power_enable_in, module_reset_n,
    output rx_data_o, rx_data_oe_n, dcd_o, dcd_oe_n, dsr_o, dsr_oe_n,
           cts_o, cts_oe_n, ri_o, ri_oe_n
  );

  modport host (
    output tx_data, dtr_n, rts, power_enable_in, module_reset_n,
    input  rx_data_o, rx_data_oe_n, dcd_o, dcd_oe_n, dsr_o, dsr_oe_n,
           cts_o, cts_oe_n, ri_o, ri_oe_n
  );
endinterface

// ===== modem_end.sv
// Modem end: serial link, handshake outputs, power and reset handling
// Function
// [R01] Outputs float while module held in reset
// [R02] Power input active high, on when high
// [R03] Host drives power input low for off
// [R04] Host drives all lines low when off; module_reset_n is left high
// [R05] Module reset input is active low
// [R06] Host holds reset low at least 5 ms
// [R07] Characters are 8 data, no parity, 1 stop
// [R08] Native language and AT commands share framing
// [R09] Carrier detect low while in network range
// [R10] High request/clear-to-send pauses the peer
// [R11] Ring indicator pulses low for waiting messages
// [R12] Ready handshakes are active low both ways
// [R13] Low start bit, data LSB first
module modem_end
  import modem_link_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Link pins
  modem_link_if.modem                link,
  // Received character
  output      modem_link_pkg::char_t rx_char,
  output      logic                  rx_valid,
  // Character to send
  input  wire modem_link_pkg::char_t tx_char,
  input  wire logic                  tx_valid,
  output      logic                  tx_ready,
  // Modem status
  input  wire logic                  network_reach_out,
  input  wire logic                  message_pending_out,
  input  wire logic                  rx_pause,
  input  wire logic                  modem_ready,
  output      logic                  powered,
  output      logic                  in_reset,
  output      logic                  host_paused,
  output      logic                  host_ready
);
  import modem_link_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] meta_reg, sync_reg;
  logic [4:0] meta_next, sync_next;

  always_comb begin
    meta_next = {link.tx_data, link.dtr_n, link.rts, link.power_enable_in, link.module_reset_n};
    sync_next = meta_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 5'h1A;
      sync_reg <= 5'h1A;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  logic rxd_s, dtr_n_s, rts_s, pwr_s, mrst_n_s;
  assign {rxd_s, dtr_n_s, rts_s, pwr_s, mrst_n_s} = sync_reg;

  logic active;
  assign active = pwr_s && mrst_n_s; // see [R02] see [R05]

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  ser_state_t       rs_reg, rs_next;
  logic [CNT_W-1:0] rc_reg, rc_next;
  logic [2:0]       rb_reg, rb_next;
  char_t            rsh_reg, rsh_next;
  char_t            rch_reg, rch_next;
  logic             rv_reg, rv_next;

  always_comb begin
    rs_next  = rs_reg;
    rc_next  = rc_reg + CNT_W'(1);
    rb_next  = rb_reg;
    rsh_next = rsh_reg;
    rch_next = rch_reg;
    rv_next  = 1'b0;
    if (!active) begin
      rs_next = SER_IDLE;
      rc_next = '0;
    end else begin
      unique case (rs_reg)
        SER_IDLE: begin
          rc_next = '0;
          if (rxd_s == START_BIT) rs_next = SER_START; // see [R13]
        end
        SER_START: begin
          if (cnt_done(rc_reg, HALF_BIT_CYCLES)) begin
            rc_next = '0;
            rb_next = '0;
            rs_next = (rxd_s == START_BIT) ? SER_DATA : SER_IDLE;
          end
        end
        SER_DATA: begin
          if (cnt_done(rc_reg, BIT_CYCLES)) begin
            rc_next  = '0;
            rsh_next = {rxd_s, rsh_reg[DATA_BITS-1:1]}; // see [R13]
            rb_next  = rb_reg + 3'h1;
            if (rb_reg == 3'(DATA_BITS - 1)) rs_next = SER_STOP; // see [R07]
          end
        end
        SER_STOP: begin
          if (cnt_done(rc_reg, BIT_CYCLES)) begin
            rs_next = SER_IDLE;
            // Framing error drops the character; no parity bit exists
            if (rxd_s == LINE_IDLE) begin // see [R07]
              rch_next = rsh_reg;
              rv_next  = 1'b1; // see [R08]
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rs_reg  <= SER_IDLE;
      rc_reg  <= '0;
      rb_reg  <= 3'h0;
      rsh_reg <= 8'h00;
      rch_reg <= 8'h00;
      rv_reg  <= 1'b0;
    end else begin
      rs_reg  <= rs_next;
      rc_reg  <= rc_next;
      rb_reg  <= rb_next;
      rsh_reg <= rsh_next;
      rch_reg <= rch_next;
      rv_reg  <= rv_next;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  ser_state_t       ts_reg, ts_next;
  logic [CNT_W-1:0] tc_reg, tc_next;
  logic [2:0]       tb_reg, tb_next;
  char_t            tsh_reg, tsh_next;
  logic             txd_reg, txd_next;
  logic             trdy_reg, trdy_next;

  always_comb begin
    ts_next   = ts_reg;
    tc_next   = tc_reg + CNT_W'(1);
    tb_next   = tb_reg;
    tsh_next  = tsh_reg;
    txd_next  = txd_reg;
    // Host pause only holds off the next character, never splits one
    trdy_next = active && !rts_s && (ts_next == SER_IDLE);  // see [R10]
    if (!active) begin
      ts_next   = SER_IDLE;
      txd_next  = LINE_IDLE;
      trdy_next = 1'b0;
    end else begin
      unique case (ts_reg)
        SER_IDLE: begin
          tc_next  = '0;
          txd_next = LINE_IDLE;
          if (tx_valid && trdy_reg) begin
            tsh_next  = tx_char;
            txd_next  = START_BIT; // see [R13]
            ts_next   = SER_START;
            trdy_next = 1'b0;
          end
        end
        SER_START: begin
          if (cnt_done(tc_reg, BIT_CYCLES)) begin
            tc_next  = '0;
            tb_next  = '0;
            txd_next = tsh_reg[0]; // see [R13]
            ts_next  = SER_DATA;
          end
        end
        SER_DATA: begin
          if (cnt_done(tc_reg, BIT_CYCLES)) begin
            tc_next = '0;
            tb_next = tb_reg + 3'h1;
            if (tb_reg == 3'(DATA_BITS - 1)) begin
              txd_next = LINE_IDLE; // see [R07]
              ts_next  = SER_STOP;
            end else begin
              txd_next = tsh_reg[tb_reg + 3'h1];
            end
          end
        end
        SER_STOP: begin
          if (cnt_done(tc_reg, BIT_CYCLES * STOP_BITS)) begin
            ts_next   = SER_IDLE;
            trdy_next = !rts_s;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ts_reg   <= SER_IDLE;
      tc_reg   <= '0;
      tb_reg   <= 3'h0;
      tsh_reg  <= 8'h00;
      txd_reg  <= 1'b1;
      trdy_reg <= 1'b0;
    end else begin
      ts_reg   <= ts_next;
      tc_reg   <= tc_next;
      tb_reg   <= tb_next;
      tsh_reg  <= tsh_next;
      txd_reg  <= txd_next;
      trdy_reg <= trdy_next;
    end
  end

  // ----------------------------------------
  // Handshake and status outputs
  // ----------------------------------------
  logic [3:0] pin_reg, pin_next;   // dcd, dsr, cts, ri
  logic       oe_n_reg, oe_n_next;
  logic [3:0] st_reg, st_next;     // powered, in_reset, paused, ready
  logic       mp_reg, mp_next;
  logic [CNT_W-1:0] ri_cnt_reg, ri_cnt_next;

  always_comb begin
    mp_next     = message_pending_out;
    ri_cnt_next = ri_cnt_reg;
    pin_next[3] = !network_reach_out; // see [R09]
    pin_next[2] = !modem_ready; // see [R12]
    pin_next[1] = rx_pause; // see [R10]
    // One low pulse per new pending message
    if (message_pending_out && !mp_reg) ri_cnt_next = CNT_W'(RING_PULSE_CYCLES);  // see [R11]
    else if (ri_cnt_reg != '0) ri_cnt_next = ri_cnt_reg - CNT_W'(1);
    pin_next[0] = (ri_cnt_next == '0);
    oe_n_next   = !active; // see [R01]
    st_next     = {pwr_s, !mrst_n_s, rts_s, !dtr_n_s};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_reg    <= 4'hF;
      oe_n_reg   <= 1'b1;
      st_reg     <= 4'h0;
      mp_reg     <= 1'b0;
      ri_cnt_reg <= '0;
    end else begin
      pin_reg    <= pin_next;
      oe_n_reg   <= oe_n_next;
      st_reg     <= st_next;
      mp_reg     <= mp_next;
      ri_cnt_reg <= ri_cnt_next;
    end
  end

  assign link.rx_data_o = txd_reg;
  assign link.rx_data_oe_n = oe_n_reg;
  assign link.dcd_o = pin_reg[3];
  assign link.dcd_oe_n = oe_n_reg;
  assign link.dsr_o = pin_reg[2];
  assign link.dsr_oe_n = oe_n_reg;
  assign link.cts_o = pin_reg[1];
  assign link.cts_oe_n = oe_n_reg;
  assign link.ri_o = pin_reg[0];
  assign link.ri_oe_n = oe_n_reg;
  assign rx_char = rch_reg;
  assign rx_valid = rv_reg;
  assign tx_ready = trdy_reg;
  assign powered = st_reg[3];
  assign in_reset = st_reg[2];
  assign host_paused = st_reg[1];
  assign host_ready = st_reg[0];
endmodule

// ===== host_end.sv
// Host end: drives power, reset pulse and serial link to the modem
module host_end
  import modem_link_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC
)(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Link pins
  modem_link_if.host                 link,
  // Control
  input  wire logic                  power_on,
  input  wire logic                  reset_req,
  input  wire logic                  host_ready_in,
  input  wire logic                  rx_pause,
  output      logic                  reset_busy,
  // Characters
  input  wire modem_link_pkg::char_t tx_char,
  input  wire logic                  tx_valid,
  output      logic                  tx_ready,
  output      modem_link_pkg::char_t rx_char,
  output      logic                  rx_valid,
  // Modem status, active high
  output      logic                  in_range,
  output      logic                  modem_ready,
  output      logic                  modem_paused,
  output      logic                  ring
);
  import modem_link_pkg::*;

  // ----------------------------------------
  // Pin synchronisers (rxd, dcd, dsr, cts, ri)
  // ----------------------------------------
  logic [4:0] meta_reg, sync_reg, meta_next;
  always_comb meta_next = {link.rx_data_o | link.rx_data_oe_n, link.dcd_o | link.dcd_oe_n,
                           link.dsr_o | link.dsr_oe_n, link.cts_o | link.cts_oe_n,
                           link.ri_o | link.ri_oe_n};
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 5'h1F;
      sync_reg <= 5'h1F;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= meta_reg;
    end
  end

  // ----------------------------------------
  // Power and reset pulse
  // ----------------------------------------
  logic [CNT_W-1:0] rcnt_reg, rcnt_next;
  logic             pwr_reg, pwr_next, mr_reg, mr_next, ctl_reg, ctl_next;
  always_comb begin
    rcnt_next = rcnt_reg;
    if (reset_req && rcnt_reg == '0) rcnt_next = CNT_W'(RESET_CYCLES);  // see [R06]
    else if (rcnt_reg != '0) rcnt_next = rcnt_reg - CNT_W'(1);
    mr_next  = (rcnt_next == '0); // see [R05]
    pwr_next = power_on; // see [R03]
    // Off means tx_data, rts and dtr_n low so the modem is not back-fed
    ctl_next = power_on; // see [R04]
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rcnt_reg <= '0;
      pwr_reg  <= 1'b0;
      mr_reg   <= 1'b1;
      ctl_reg  <= 1'b0;
    end else begin
      rcnt_reg <= rcnt_next;
      pwr_reg  <= pwr_next;
      mr_reg   <= mr_next;
      ctl_reg  <= ctl_next;
    end
  end

  // ----------------------------------------
  // Serial engine (8N1, LSB first)
  // ----------------------------------------
  ser_state_t       ts_reg, ts_next, rs_reg, rs_next;
  logic [CNT_W-1:0] tc_reg, tc_next, rc_reg, rc_next;
  logic [3:0]       tb_reg, tb_next, rb_reg, rb_next;
  char_t            tsh_reg, tsh_next, rsh_reg, rsh_next, rch_reg, rch_next;
  logic             txd_reg, txd_next, rv_reg, rv_next, trdy_reg, trdy_next;
  logic             rxd_s;
  assign rxd_s = sync_reg[4];

  always_comb begin
    ts_next = ts_reg; tc_next = tc_reg + CNT_W'(1); tb_next = tb_reg;
    tsh_next = tsh_reg; txd_next = txd_reg;
    trdy_next = 1'b0;
    unique case (ts_reg)
      SER_IDLE: begin
        tc_next   = '0;
        txd_next  = LINE_IDLE;
        trdy_next = ctl_reg && !sync_reg[1]; // see [R10]
        if (tx_valid && trdy_reg) begin
          tsh_next = tx_char; txd_next = START_BIT; ts_next = SER_START; trdy_next = 1'b0;
        end
      end
      SER_START, SER_DATA: if (cnt_done(tc_reg, BIT_CYCLES)) begin
        tc_next = '0;
        tb_next = (ts_reg == SER_START) ? 4'h0 : tb_reg + 4'h1;
        ts_next = SER_DATA;
        if (tb_next == 4'(DATA_BITS)) begin
          txd_next = LINE_IDLE; ts_next = SER_STOP; // see [R07]
        end else txd_next = tsh_reg[tb_next[2:0]]; // see [R13]
      end
      SER_STOP: if (cnt_done(tc_reg, BIT_CYCLES)) ts_next = SER_IDLE;
    endcase
    if (!ctl_reg) begin
      ts_next = SER_IDLE; txd_next = 1'b0;
    end

    rs_next = rs_reg; rc_next = rc_reg + CNT_W'(1); rb_next = rb_reg;
    rsh_next = rsh_reg; rch_next = rch_reg; rv_next = 1'b0;
    unique case (rs_reg)
      SER_IDLE: begin
        rc_next = '0;
        if (rxd_s == START_BIT && ctl_reg) rs_next = SER_START;
      end
      SER_START: if (cnt_done(rc_reg, HALF_BIT_CYCLES)) begin
        rc_next = '0; rb_next = '0;
        rs_next = (rxd_s == START_BIT) ? SER_DATA : SER_IDLE;
      end
      SER_DATA: if (cnt_done(rc_reg, BIT_CYCLES)) begin
        rc_next = '0; rsh_next = {rxd_s, rsh_reg[DATA_BITS-1:1]}; rb_next = rb_reg + 4'h1;
        if (rb_next == 4'(DATA_BITS)) rs_next = SER_STOP;
      end
      SER_STOP: if (cnt_done(rc_reg, BIT_CYCLES)) begin
        rs_next = SER_IDLE;
        if (rxd_s == LINE_IDLE) begin
          rch_next = rsh_reg; rv_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ts_reg <= SER_IDLE; tc_reg <= '0; tb_reg <= 4'h0; tsh_reg <= 8'h00;
      txd_reg <= 1'b0; trdy_reg <= 1'b0;
      rs_reg <= SER_IDLE; rc_reg <= '0; rb_reg <= 4'h0; rsh_reg <= 8'h00;
      rch_reg <= 8'h00; rv_reg <= 1'b0;
    end else begin
      ts_reg <= ts_next; tc_reg <= tc_next; tb_reg <= tb_next; tsh_reg <= tsh_next;
      txd_reg <= txd_next; trdy_reg <= trdy_next;
      rs_reg <= rs_next; rc_reg <= rc_next; rb_reg <= rb_next; rsh_reg <= rsh_next;
      rch_reg <= rch_next; rv_reg <= rv_next;
    end
  end

  // ----------------------------------------
  // Status and handshake outputs
  // ----------------------------------------
  logic [5:0] st_reg, st_next;
  always_comb begin
    st_next = {ctl_reg && !host_ready_in, ctl_reg && rx_pause,   // see [R12] see [R10]
               !sync_reg[3], !sync_reg[2], sync_reg[1], !sync_reg[0]};
  end
  always_ff @(posedge clock) begin
    if (rst) st_reg <= 6'h00;
    else     st_reg <= st_next;
  end

  assign link.tx_data = txd_reg;
  assign link.dtr_n = st_reg[5];
  assign link.rts = st_reg[4];
  assign link.power_enable_in = pwr_reg; // see [R02]
  assign link.module_reset_n = mr_reg;
  assign reset_busy = !mr_reg;
  assign tx_ready = trdy_reg;
  assign rx_char = rch_reg;
  assign rx_valid = rv_reg;
  assign in_range = st_reg[3];
  assign modem_ready = st_reg[2];
  assign modem_paused = st_reg[1];
  assign ring = st_reg[0];
endmodule

// ===== modem_link_sva.sv
// Assertion checker for the pins between host and modem ends
module modem_link_sva
  import modem_link_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = 100
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link pins
  input wire logic tx_data,
  input wire logic rx_data_o,
  input wire logic rx_data_oe_n,
  input wire logic dcd_oe_n,
  input wire logic dsr_oe_n,
  input wire logic cts_o,
  input wire logic cts_oe_n,
  input wire logic ri_o,
  input wire logic ri_oe_n,
  input wire logic dtr_n,
  input wire logic rts,
  input wire logic power_enable_in,
  input wire logic module_reset_n
);
  // ----------------------------------------
  // Frame trackers, lane 0 host line, lane 1 modem line
  // ----------------------------------------
  localparam int unsigned STOP_MID = BIT_CYCLES * 9 + HALF_BIT_CYCLES;
  logic [1:0]  ln, on, start_w, prev_reg, busy_reg, busy_next;
  logic [31:0] cnt_reg [2];
  logic [31:0] cnt_next [2];
  logic [31:0] ri_reg, ri_next, rl_reg, rl_next;
  logic        pl_reg, pl_next, oe_all;
  assign ln      = {rx_data_o, tx_data};
  assign on      = {!rx_data_oe_n, power_enable_in && module_reset_n};
  assign start_w = ~busy_reg & prev_reg & ~ln & on;
  assign oe_all  = &{rx_data_oe_n, dcd_oe_n, dsr_oe_n, cts_oe_n, ri_oe_n};
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      busy_next[i] = busy_reg[i];
      cnt_next[i]  = cnt_reg[i] + 32'h1;
      if (!busy_reg[i]) begin
        busy_next[i] = start_w[i];
        cnt_next[i]  = 32'h1;
      end else if (cnt_reg[i] == STOP_MID) begin
        busy_next[i] = 1'b0;
      end
    end
    ri_next = (!ri_o && !ri_oe_n) ? ri_reg + 32'h1 : 32'h0;
    rl_next = module_reset_n ? 32'h0 : rl_reg + 32'h1;
    // Stretches overlapping power-off are not host reset pulses
    pl_next = module_reset_n ? 1'b0 : (pl_reg || !power_enable_in);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_reg <= 2'h3;
      busy_reg <= 2'h0;
      cnt_reg  <= '{32'h0, 32'h0};
      ri_reg   <= 32'h0;
      rl_reg   <= 32'h0;
      pl_reg   <= 1'b0;
    end else begin
      prev_reg <= ln;
      busy_reg <= busy_next;
      cnt_reg  <= cnt_next;
      ri_reg   <= ri_next;
      rl_reg   <= rl_next;
      pl_reg   <= pl_next;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence held_reset;
    (!module_reset_n)[*5];
  endsequence
  sequence held_off;
    (!power_enable_in)[*5];
  endsequence
  a_float_in_reset: assert property (held_reset |-> oe_all)
    else $error("modem drove pins in reset");
  a_float_power_off: assert property (held_off |-> oe_all)
    else $error("modem drove pins while off");
  a_off_lines_low: assert property ((!power_enable_in)[*4] |-> !tx_data && !rts && !dtr_n)
    else $error("host lines high while off");
  a_reset_pulse_width: assert property ($rose(module_reset_n) && !pl_reg |-> rl_reg >= RESET_CYCLES)
    else $error("module reset pulse too short");
  a_tx_start_bit: assert property (busy_reg[0] && cnt_reg[0] == HALF_BIT_CYCLES && on[0] |-> !tx_data)
    else $error("host start bit not low at mid bit");
  a_tx_stop_bit: assert property (busy_reg[0] && cnt_reg[0] == STOP_MID && on[0] |-> tx_data)
    else $error("host stop bit not high");
  a_rx_stop_bit: assert property (busy_reg[1] && cnt_reg[1] == STOP_MID && on[1] |-> rx_data_o)
    else $error("modem stop bit not high");
  a_rts_pauses_modem: assert property (rts[*8] |-> !start_w[1])
    else $error("modem sent while paused");
  a_cts_pauses_host: assert property ((cts_o && !cts_oe_n)[*8] |-> !start_w[0])
    else $error("host sent while paused");
  a_ring_width: assert property ($rose(ri_o) && !ri_oe_n && ri_reg != 0 |->
    ri_reg >= RING_PULSE_CYCLES - 1 && ri_reg <= RING_PULSE_CYCLES + 1)
    else $error("ring pulse width wrong");
endmodule

// ===== modem_host_port_control_tb.sv
// Self-checking bench joining host and modem ends
module modem_host_port_control_tb
  import modem_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned RST_CYC = 100;
  localparam int          LIMIT   = 90000;
  logic  clock = 1'b0, rst = 1'b1;
  logic  power_on = 1'b1, reset_req = 1'b0, host_ready_in = 1'b0, h_pause = 1'b0, h_tx_valid = 1'b0;
  logic  m_tx_valid = 1'b0, reach = 1'b0, pending = 1'b0, m_pause = 1'b0, m_ready = 1'b0;
  char_t h_tx_char = 8'h00, m_tx_char = 8'h00, h_rx_char, m_rx_char;
  logic  reset_busy, h_tx_ready, h_rx_valid, in_range, m_ready_seen, modem_paused, ring;
  logic  m_rx_valid, m_tx_ready, powered, in_reset, host_paused, host_ready;
  int    err_count = 0, checks = 0, cycles = 0;
  modem_link_if link();
  modem_end modem_end_inst (.clock, .rst, .link, .rx_char(m_rx_char), .rx_valid(m_rx_valid),
    .tx_char(m_tx_char), .tx_valid(m_tx_valid), .tx_ready(m_tx_ready), .network_reach_out(reach),
    .message_pending_out(pending), .rx_pause(m_pause), .modem_ready(m_ready), .powered,
    .in_reset, .host_paused, .host_ready);
  host_end #(.RESET_CYCLES(RST_CYC)) host_end_inst (.clock, .rst, .link, .power_on,
    .reset_req, .host_ready_in, .rx_pause(h_pause), .reset_busy,
    .tx_char(h_tx_char), .tx_valid(h_tx_valid), .tx_ready(h_tx_ready), .rx_char(h_rx_char),
    .rx_valid(h_rx_valid), .in_range, .modem_ready(m_ready_seen), .modem_paused, .ring);
  modem_link_sva #(.RESET_CYCLES(RST_CYC)) modem_link_sva_inst (.clock, .rst,
    .tx_data(link.tx_data), .rx_data_o(link.rx_data_o), .rx_data_oe_n(link.rx_data_oe_n),
    .dcd_oe_n(link.dcd_oe_n), .dsr_oe_n(link.dsr_oe_n), .cts_o(link.cts_o), .cts_oe_n(link.cts_oe_n),
    .ri_o(link.ri_o), .ri_oe_n(link.ri_oe_n), .dtr_n(link.dtr_n), .rts(link.rts),
    .power_enable_in(link.power_enable_in), .module_reset_n(link.module_reset_n));
  wire logic [4:0] oe_vec = {link.rx_data_oe_n, link.dcd_oe_n, link.dsr_oe_n, link.cts_oe_n, link.ri_oe_n};

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Inputs always change 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic line(input bit m);
    return m ? link.rx_data_o : link.tx_data;
  endfunction
  // Request held until the edge that samples ready high
  task automatic send(input bit m, input char_t c);
    int n = 0;
    if (m) begin m_tx_char = c; m_tx_valid = 1'b1; end else begin h_tx_char = c; h_tx_valid = 1'b1; end
    while ((m ? m_tx_ready : h_tx_ready) !== 1'b1 && n < 60000) begin tick(1); n++; end
    tick(1);
    if (m) m_tx_valid = 1'b0;
    else h_tx_valid = 1'b0;
  endtask
  task automatic recv(input bit m, input char_t c);
    int n = 0;
    while ((m ? m_rx_valid : h_rx_valid) !== 1'b1 && n < 60000) begin tick(1); n++; end
    check(m ? "modem rx_char" : "host rx_char", c, m ? m_rx_char : h_rx_char);
  endtask
  // Mid-bit samples of one frame
  task automatic watch(input bit m, input char_t c);
    logic [9:0] got;
    int         n = 0;
    while (line(m) !== 1'b0 && n < 5000) begin tick(1); n++; end
    tick(int'(HALF_BIT_CYCLES));
    for (int i = 0; i < 10; i++) begin
      got[i] = line(m);
      if (i < 9) tick(int'(BIT_CYCLES));
    end
    check(m ? "modem frame" : "host frame", {1'b1, c, 1'b0}, got);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    int n = 0;
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    while (link.module_reset_n !== 1'b0 && n < 20) begin tick(1); n++; end
    n = 0;
    while (link.module_reset_n === 1'b0 && n < 1000) begin
      if (n == 10) begin
        check("oe_n in reset", 5'h1F, oe_vec);
        check("in_reset", 1, in_reset);
        check("reset_busy", 1, reset_busy);
      end
      tick(1);
      n++;
    end
    check("reset width", 1, 32'(n >= RST_CYC));
    tick(8);
    check("in_reset after", 0, in_reset);
    check("oe_n after", 5'h00, oe_vec);
  endtask
  task automatic t_power();
    power_on = 1'b0;
    tick(8);
    check("power pin", 0, link.power_enable_in);
    check("lines off", 0, {link.tx_data, link.rts, link.dtr_n});
    check("powered off", 0, powered);
    check("oe_n off", 5'h1F, oe_vec);
    tick(200);
    power_on = 1'b1;
    tick(8);
    check("powered on", 1, powered);
  endtask
  task automatic t_status();
    for (int v = 1; v >= 0; v--) begin
      reach = v[0]; m_ready = v[0]; host_ready_in = v[0]; h_pause = v[0]; m_pause = v[0];
      tick(8);
      check("dcd", !v[0], link.dcd_o);
      check("in_range", v[0], in_range);
      check("dsr", !v[0], link.dsr_o);
      check("modem_ready", v[0], m_ready_seen);
      check("dtr_n", !v[0], link.dtr_n);
      check("host_ready", v[0], host_ready);
      check("rts", v[0], link.rts);
      check("host_paused", v[0], host_paused);
      check("cts", v[0], link.cts_o);
      check("modem_paused", v[0], modem_paused);
    end
  endtask
  // AT-style byte one way, native byte the other
  task automatic t_chars();
    fork
      send(0, 8'h41);
      recv(1, 8'h41);
      watch(0, 8'h41);
      send(1, 8'hA6);
      recv(0, 8'hA6);
      watch(1, 8'hA6);
    join
  endtask
  task automatic t_pause();
    logic quiet;
    quiet = 1'b1;
    h_pause = 1'b1;
    m_pause = 1'b1;
    tick(10);
    fork
      begin send(1, 8'h3C); recv(0, 8'h3C); end
      begin send(0, 8'h5A); recv(1, 8'h5A); end
      begin
        repeat (2000) begin
          if (link.tx_data !== 1'b1 || link.rx_data_o !== 1'b1) quiet = 1'b0;
          tick(1);
        end
        check("idle while paused", 1, quiet);
        h_pause = 1'b0;
        m_pause = 1'b0;
      end
    join
  endtask
  task automatic t_ring();
    int n = 0;
    pending = 1'b1;
    while (link.ri_o !== 1'b0 && n < 20) begin tick(1); n++; end
    n = 0;
    while (link.ri_o === 1'b0 && n < 20000) begin
      if (n == 10) check("ring", 1, ring);
      tick(1);
      n++;
    end
    check("ring width", 1, 32'(n >= RING_PULSE_CYCLES - 1 && n <= RING_PULSE_CYCLES + 1));
    pending = 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    tick(6);
    t_reset();
    t_power();
    t_status();
    t_chars();
    t_pause();
    t_ring();
    final_report();
  end
endmodule
